//--- hw/scc_top.v
/*
 * Sample clock and first slot configuration: Wishbone classic register
 * slave, slow sample clock generation with trim and external bypass,
 * fast timing clock trim, sample trigger selection and FIFO format decode.
 * Assumes a 100 MHz clock, an asynchronous active-low reset and general
 * pins that are asynchronous to the clock. Each register is one 32-bit
 * bus word of which only the low 16 bits are stored.
 */
// The Wishbone interface to the registers was decided locally.
`include "scc_defines.vh"

module scc_top (
  input  wire        clock,
  input  wire        arst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        general_pin_zero,
  input  wire        general_pin_one,
  output reg         sample_clock_tick,
  output reg         timing_clock_tick,
  output reg         sample_start,
  output reg         first_slot_enable,
  output reg  [2:0]  first_slot_fifo_format,
  output reg  [3:0]  fifo_halfwords,
  output reg  [5:0]  slow_clock_trim,
  output reg  [7:0]  fast_clock_trim,
  output reg         pin_zero_input_enable,
  output reg         pin_one_input_enable
);

  // Reset release.
  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Register storage.
  reg [15:0] slot_fifo_config_q;
  reg [15:0] sample_rate_setting_q;
  reg [15:0] ext_trigger_startup_q;
  reg [15:0] slow_clock_control_q;
  reg [15:0] fast_clock_trim_q;
  reg [15:0] pin_control_q;

  // Decoded fields.
  wire [2:0] fmt_w     = slot_fifo_config_q[`SCC_FMT_HI:`SCC_FMT_LO];
  wire       slot_en_w = slot_fifo_config_q[`SCC_SLOT_EN_BIT];
  wire       bypass_w  = slow_clock_control_q[`SCC_BYP_BIT];
  wire       clk_en_w  = slow_clock_control_q[`SCC_CLKEN_BIT];
  wire [5:0] strim_w   = slow_clock_control_q[`SCC_STRIM_HI:`SCC_STRIM_LO];
  wire [7:0] ftrim_w   = fast_clock_trim_q[`SCC_FTRIM_HI:`SCC_FTRIM_LO];
  wire [1:0] sel_w     = pin_control_q[`SCC_SEL_HI:`SCC_SEL_LO];
  wire [1:0] pin1_mode = pin_control_q[`SCC_PIN1_HI:`SCC_PIN1_LO];

  // Number of 16-bit FIFO words each sample of the slot produces.
  function [3:0] fmt_halfwords;
    input [2:0] fmt;
    begin
      case (fmt)
        `SCC_FMT_NONE:  fmt_halfwords = 4'h0;
        `SCC_FMT_SUM16: fmt_halfwords = 4'h1;
        `SCC_FMT_SUM32: fmt_halfwords = 4'h2;
        `SCC_FMT_CH16:  fmt_halfwords = 4'h4;
        `SCC_FMT_CH32:  fmt_halfwords = 4'h8;
        default:        fmt_halfwords = 4'h0;
      endcase
    end
  endfunction

  function fmt_reserved;
    input [2:0] fmt;
    begin
      case (fmt)
        `SCC_FMT_NONE, `SCC_FMT_SUM16, `SCC_FMT_SUM32,
        `SCC_FMT_CH16, `SCC_FMT_CH32: fmt_reserved = 1'b0;
        default:                      fmt_reserved = 1'b1;
      endcase
    end
  endfunction

  // Status bits that software reads back to catch a bad setup.
  // The register is read-only, so a stray write cannot hide the fault.
  wire startup_word_bad_w =
    ((sel_w == `SCC_SEL_PIN0) || (sel_w == `SCC_SEL_PIN1)) ?
    (ext_trigger_startup_q != `SCC_STARTUP_WORD) :
    (ext_trigger_startup_q != `SCC_RST_EXT_STARTUP);
  wire bypass_pin_bad_w   = bypass_w && (pin1_mode != `SCC_PIN1_AS_INPUT);
  wire trigger_res_w      = (sel_w == `SCC_SEL_RESERVED);

  // Wishbone classic slave: ack comes one cycle after the request and the
  // write is committed on the edge at which the master samples ack.
  wire       req_w = wb_cyc_i & wb_stb_i;
  wire [7:0] idx_w = wb_adr_i[9:2];
  wire       wr_w  = req_w & wb_we_i & wb_ack_o;
  wire       ack_d = req_w & ~wb_ack_o;

  // One strobe per writable register; each fires only on the edge that sees ack.
  wire       wr_slot_w  = wr_w & (idx_w == `SCC_IDX_SLOT_CFG);
  wire       wr_rate_w  = wr_w & (idx_w == `SCC_IDX_SAMPLE_RATE);
  wire       wr_start_w = wr_w & (idx_w == `SCC_IDX_EXT_STARTUP);
  wire       wr_slow_w  = wr_w & (idx_w == `SCC_IDX_SLOW_CTRL);
  wire       wr_fast_w  = wr_w & (idx_w == `SCC_IDX_FAST_TRIM);
  wire       wr_pin_w   = wr_w & (idx_w == `SCC_IDX_PIN_CTRL);

  function [15:0] merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  sel;
    begin
      merge = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  reg [31:0] rd_d;
  reg [15:0] status_d;

  always @* begin
    status_d = {12'h000, trigger_res_w, bypass_pin_bad_w, startup_word_bad_w,
                fmt_reserved(fmt_w)};
    case (idx_w)
      `SCC_IDX_SLOT_CFG:    rd_d = {16'h0000, slot_fifo_config_q};
      `SCC_IDX_SAMPLE_RATE: rd_d = {16'h0000, sample_rate_setting_q};
      `SCC_IDX_EXT_STARTUP: rd_d = {16'h0000, ext_trigger_startup_q};
      `SCC_IDX_SLOW_CTRL:   rd_d = {16'h0000, slow_clock_control_q};
      `SCC_IDX_FAST_TRIM:   rd_d = {16'h0000, fast_clock_trim_q};
      `SCC_IDX_PIN_CTRL:    rd_d = {16'h0000, pin_control_q};
      `SCC_IDX_STATUS:      rd_d = {16'h0000, status_d};
      default:              rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= ack_d;
      // Read data is captured with the request and held until the next one.
      if (ack_d) begin
        wb_dat_o <= rd_d;
      end
    end
  end

  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      slot_fifo_config_q    <= `SCC_RST_SLOT_CFG;
      sample_rate_setting_q <= `SCC_RST_SAMPLE_RATE;
      ext_trigger_startup_q <= `SCC_RST_EXT_STARTUP;
      slow_clock_control_q  <= `SCC_RST_SLOW_CTRL;
      fast_clock_trim_q     <= `SCC_RST_FAST_TRIM;
      pin_control_q         <= `SCC_RST_PIN_CTRL;
    end else begin
      // Reserved bits are stored as written and read back unchanged.
      if (wr_slot_w) begin
        slot_fifo_config_q <= merge(slot_fifo_config_q, wb_dat_i, wb_sel_i);
      end
      if (wr_rate_w) begin
        sample_rate_setting_q <= merge(sample_rate_setting_q, wb_dat_i, wb_sel_i);
      end
      if (wr_start_w) begin
        ext_trigger_startup_q <= merge(ext_trigger_startup_q, wb_dat_i, wb_sel_i);
      end
      if (wr_slow_w) begin
        slow_clock_control_q <= merge(slow_clock_control_q, wb_dat_i, wb_sel_i);
      end
      if (wr_fast_w) begin
        fast_clock_trim_q <= merge(fast_clock_trim_q, wb_dat_i, wb_sel_i);
      end
      if (wr_pin_w) begin
        pin_control_q <= merge(pin_control_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // General pins; each passes two flip-flops before any logic reads it.
  wire pin0_rise_w;
  wire pin1_rise_w;

  scc_pin_sync u_pin0 (
    .clock   (clock),
    .rst_n   (rst_n_q),
    .pin     (general_pin_zero),
    .level_q (),
    .rise_q  (pin0_rise_w)
  );

  scc_pin_sync u_pin1 (
    .clock   (clock),
    .rst_n   (rst_n_q),
    .pin     (general_pin_one),
    .level_q (),
    .rise_q  (pin1_rise_w)
  );

  // Slow sample oscillator. The highest rate sits at code zero so that a
  // larger code always gives a lower rate.
  localparam [63:0] SLOW_MAX_HZ = `SCC_SLOW_CENTER_HZ +
                                  `SCC_SLOW_CENTER_CODE * `SCC_SLOW_STEP_HZ;
  wire slow_tick_w;

  scc_nco #(
    .TRIM_W    (6),
    .BASE_HZ   (SLOW_MAX_HZ),
    .STEP_HZ   (`SCC_SLOW_STEP_HZ),
    .STEP_DOWN (1)
  ) u_slow (
    .clock  (clock),
    .rst_n  (rst_n_q),
    .run    (clk_en_w & ~bypass_w),
    .trim   (strim_w),
    .tick_q (slow_tick_w)
  );

  // Fast timing oscillator, rising with the code around its default.
  localparam [63:0] FAST_MIN_HZ = `SCC_FAST_DEFAULT_HZ -
                                  `SCC_FAST_DEFAULT_CODE * `SCC_FAST_STEP_HZ;
  wire fast_tick_w;

  scc_nco #(
    .TRIM_W    (8),
    .BASE_HZ   (FAST_MIN_HZ),
    .STEP_HZ   (`SCC_FAST_STEP_HZ),
    .STEP_DOWN (0)
  ) u_fast (
    .clock  (clock),
    .rst_n  (rst_n_q),
    .run    (1'b1),
    .trim   (ftrim_w),
    .tick_q (fast_tick_w)
  );

  // Pin ticks are gated as well, so clearing bit 7 stops the sample clock and internal trigger in both modes.
  // bypass source select
  wire sample_src_w = clk_en_w & (bypass_w ? pin1_rise_w : slow_tick_w);

  // Internal trigger: one sample cycle every sample_rate_setting ticks of
  // the sample clock; a setting of zero behaves as one.
  reg  [15:0] rate_cnt_q;
  reg  [15:0] rate_cnt_d;
  wire [15:0] rate_last_w = (sample_rate_setting_q == 16'h0000) ?
                            16'h0000 : (sample_rate_setting_q - 16'h0001);
  wire        rate_hit_w  = sample_src_w && (rate_cnt_q >= rate_last_w);

  always @* begin
    rate_cnt_d = rate_cnt_q;
    if (!slot_en_w || !clk_en_w) begin
      rate_cnt_d = 16'h0000;
    end else if (sample_src_w) begin
      rate_cnt_d = rate_hit_w ? 16'h0000 : (rate_cnt_q + 16'h0001);
    end
  end

  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rate_cnt_q <= 16'h0000;
    end else begin
      rate_cnt_q <= rate_cnt_d;
    end
  end

  reg start_d;

  always @* begin
    case (sel_w)
      `SCC_SEL_INTERNAL: start_d = rate_hit_w;
      `SCC_SEL_PIN0:     start_d = pin0_rise_w;
      `SCC_SEL_PIN1:     start_d = pin1_rise_w;
      default:           start_d = 1'b0;
    endcase
  end

  // Registered pulse outputs.
  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sample_clock_tick      <= 1'b0;
      timing_clock_tick      <= 1'b0;
      sample_start           <= 1'b0;
    end else begin
      sample_clock_tick      <= sample_src_w;
      timing_clock_tick      <= fast_tick_w;
      sample_start           <= slot_en_w & start_d;
    end
  end

  // Registered copies of the configuration fields.
  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      first_slot_enable      <= 1'b0;
      first_slot_fifo_format <= `SCC_FMT_NONE;
      fifo_halfwords         <= 4'h0;
      slow_clock_trim        <= 6'h00;
      fast_clock_trim        <= 8'h00;
      pin_zero_input_enable  <= 1'b0;
      pin_one_input_enable   <= 1'b0;
    end else begin
      first_slot_enable      <= slot_en_w;
      first_slot_fifo_format <= fmt_w;
      fifo_halfwords         <= fmt_halfwords(fmt_w);
      slow_clock_trim        <= strim_w;
      fast_clock_trim        <= ftrim_w;
      pin_zero_input_enable  <= pin_control_q[`SCC_PIN0_IE_BIT];
      pin_one_input_enable   <= pin1_mode == `SCC_PIN1_AS_INPUT;
    end
  end

endmodule // scc_top

//--- hw/scc_defines.vh
/*
 * Constants for the sample clock and slot configuration block: register
 * indices, field positions, reset values and clock figures.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define SCC_IDX_SLOT_CFG     8'h11
`define SCC_IDX_SAMPLE_RATE  8'h12
`define SCC_IDX_EXT_STARTUP  8'h38
`define SCC_IDX_SLOW_CTRL    8'h4B
`define SCC_IDX_FAST_TRIM    8'h4D
`define SCC_IDX_PIN_CTRL     8'h4F
`define SCC_IDX_STATUS       8'h70

// Reset values.
`define SCC_RST_SLOT_CFG     16'h1000
`define SCC_RST_SAMPLE_RATE  16'h0008
`define SCC_RST_EXT_STARTUP  16'h0000
`define SCC_RST_SLOW_CTRL    16'h2612
`define SCC_RST_FAST_TRIM    16'h0098
`define SCC_RST_PIN_CTRL     16'h2010

// Field positions.
`define SCC_SLOT_EN_BIT      0
`define SCC_FMT_HI           4
`define SCC_FMT_LO           2
`define SCC_BYP_BIT          8
`define SCC_CLKEN_BIT        7
`define SCC_STRIM_HI         5
`define SCC_STRIM_LO         0
`define SCC_FTRIM_HI         7
`define SCC_FTRIM_LO         0
`define SCC_SEL_HI           3
`define SCC_SEL_LO           2
`define SCC_PIN0_IE_BIT      1
`define SCC_PIN1_HI          6
`define SCC_PIN1_LO          5

// Field codes.
`define SCC_FMT_NONE         3'h0
`define SCC_FMT_SUM16        3'h1
`define SCC_FMT_SUM32        3'h2
`define SCC_FMT_CH16         3'h4
`define SCC_FMT_CH32         3'h6
`define SCC_SEL_INTERNAL     2'h0
`define SCC_SEL_PIN0         2'h1
`define SCC_SEL_PIN1         2'h2
`define SCC_SEL_RESERVED     2'h3
`define SCC_PIN1_AS_INPUT    2'h1
`define SCC_STARTUP_WORD     16'h4000

// Clock figures in Hz, centre trim codes and accumulator width in bits.
`define SCC_CLK_HZ           64'd100000000
`define SCC_SLOW_CENTER_HZ   64'd32768
`define SCC_SLOW_STEP_HZ     64'd600
`define SCC_SLOW_CENTER_CODE 64'd34
`define SCC_FAST_DEFAULT_HZ  64'd32000000
`define SCC_FAST_STEP_HZ     64'd109000
`define SCC_FAST_DEFAULT_CODE 64'd152
`define SCC_ACC_W            24

`endif

//--- hw/scc_nco.v
/*
 * Trimmable rate generator: a phase accumulator that emits a one-cycle
 * enable pulse on each wrap, with its rate set by a trim code.
 * Assumes trim comes from a register on the same clock.
 */
`include "scc_defines.vh"

module scc_nco #(
  parameter         TRIM_W   = 6,
  parameter         ACC_W    = `SCC_ACC_W,
  parameter [63:0]  BASE_HZ  = 64'd53168,
  parameter [63:0]  STEP_HZ  = 64'd600,
  parameter         STEP_DOWN = 1
) (
  input  wire              clock,
  input  wire              rst_n,
  input  wire              run,
  input  wire [TRIM_W-1:0] trim,
  output reg               tick_q
);
  localparam [63:0] CLK_HZ   = `SCC_CLK_HZ;
  localparam [63:0] BASE_INC = (BASE_HZ << ACC_W) / CLK_HZ;
  localparam [63:0] STEP_INC = (STEP_HZ << ACC_W) / CLK_HZ;

  reg  [ACC_W-1:0] acc_q;
  wire [63:0]      step_w = STEP_INC * {{(64-TRIM_W){1'b0}}, trim};
  wire [63:0]      inc_w  = STEP_DOWN ? (BASE_INC - step_w) : (BASE_INC + step_w);
  wire [ACC_W:0]   sum_w  = {1'b0, acc_q} + {1'b0, inc_w[ACC_W-1:0]};

  // The step is truncated to whole increments, so the trim slope is
  // accurate only to the accumulator's resolution.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q  <= {ACC_W{1'b0}};
      tick_q <= 1'b0;
    end else if (run) begin
      acc_q  <= sum_w[ACC_W-1:0];
      tick_q <= sum_w[ACC_W];
    end else begin
      tick_q <= 1'b0;
    end
  end
endmodule // scc_nco

//--- hw/scc_pin_sync.v
/*
 * Two-stage synchroniser for a general pin with a rising edge pulse.
 * Assumes the pin is asynchronous to clock.
 */
module scc_pin_sync (
  input  wire clock,
  input  wire rst_n,
  input  wire pin,
  output reg  level_q,
  output reg  rise_q
);
  reg meta_q;
  reg sync_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      meta_q  <= pin;
      sync_q  <= meta_q;
      level_q <= sync_q;
      rise_q  <= sync_q & ~level_q;
    end
  end
endmodule // scc_pin_sync

//--- test/scc_top_assertions.sv
/*
 * Checker for scc_top: bus answer timing, register copies, gating of ticks.
 * Assumes it sees only the top ports and shadows writes taken at the ack edge.
 */
module scc_top_assertions (
  input wire        clock,
  input wire        arst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [9:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        general_pin_zero,
  input wire        general_pin_one,
  input wire        sample_clock_tick,
  input wire        timing_clock_tick,
  input wire        sample_start,
  input wire        first_slot_enable,
  input wire [2:0]  first_slot_fifo_format,
  input wire [3:0]  fifo_halfwords,
  input wire [5:0]  slow_clock_trim,
  input wire [7:0]  fast_clock_trim,
  input wire        pin_zero_input_enable,
  input wire        pin_one_input_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [15:0] slot_q, slow_q, fast_q, pin_q;
  wire        wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire [7:0]  idx = wb_adr_i[9:2];

  function automatic [15:0] mrg(input [15:0] o);
    mrg = {wb_sel_i[1] ? wb_dat_i[15:8] : o[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : o[7:0]};
  endfunction

  function automatic [3:0] words(input [2:0] f);
    words = (f == 3'h6) ? 4'h8 : (f == 3'h3 || f > 3'h4) ? 4'h0 : {1'b0, f};
  endfunction

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slot_q <= 16'h1000;
      slow_q <= 16'h2612;
      fast_q <= 16'h0098;
      pin_q  <= 16'h2010;
    end else if (wr) begin
      if (idx == 8'h11) slot_q <= mrg(slot_q);
      if (idx == 8'h4B) slow_q <= mrg(slow_q);
      if (idx == 8'h4D) fast_q <= mrg(fast_q);
      if (idx == 8'h4F) pin_q <= mrg(pin_q);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
  chk_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_slot_copy:
    assert property (wr && idx == 8'h11 |-> ##[1:3] first_slot_enable == slot_q[0]
      && first_slot_fifo_format == slot_q[4:2]) else $error("slot fields wrong");
  chk_fmt_words:
    assert property ($stable(first_slot_fifo_format) |->
      fifo_halfwords == words(first_slot_fifo_format)) else $error("fifo words wrong");
  chk_slow_trim:
    assert property (wr && idx == 8'h4B |-> ##[1:3] slow_clock_trim == slow_q[5:0])
      else $error("slow trim wrong");
  chk_fast_trim:
    assert property (wr && idx == 8'h4D |-> ##[1:3] fast_clock_trim == fast_q[7:0])
      else $error("fast trim wrong");
  chk_tick_gated:
    assert property (sample_clock_tick |-> slow_q[7] || $past(slow_q[7], 3))
      else $error("tick while clock off");
  chk_start_gated:
    assert property (sample_start |-> first_slot_enable && pin_q[3:2] != 2'h3)
      else $error("start while slot off");
  chk_start_tick:
    assert property (sample_start && pin_q[3:2] == 2'h0 |-> sample_clock_tick)
      else $error("internal start without tick");
  chk_bypass_tick:
    assert property ($rose(general_pin_one) && slow_q[8] && slow_q[7] |->
      ##[1:6] sample_clock_tick) else $error("pin one edge gave no tick");
  chk_pin_enables:
    assert property (wr && idx == 8'h4F |-> ##[1:3] pin_zero_input_enable == pin_q[1]
      && pin_one_input_enable == (pin_q[6:5] == 2'h1)) else $error("pin enables wrong");
endmodule // scc_top_assertions

bind scc_top scc_top_assertions chk_i (.*);

//--- test/scc_top_tb_top.sv
/*
 * Self-checking bench for scc_top: reads are noted in a queue and checked
 * when ack comes. Assumes the checker is bound to the design.
 */
module scc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, general_pin_zero, general_pin_one;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, sample_clock_tick, timing_clock_tick, sample_start, first_slot_enable;
  wire         pin_zero_input_enable, pin_one_input_enable;
  wire  [2:0]  first_slot_fifo_format;
  wire  [3:0]  fifo_halfwords;
  wire  [5:0]  slow_clock_trim;
  wire  [7:0]  fast_clock_trim;
  int          error_cnt = 0, checks_done = 0, n_start, n_tick, n_fast, a, i;
  int          cnt [3], fst [3];
  integer      seed = 32'hd5cf_92cf;
  logic [31:0] expq [$];
  logic [15:0] r;
  logic [7:0]  ridx [6] = '{8'h11, 8'h38, 8'h4B, 8'h4D, 8'h4F, 8'h20};
  logic [15:0] rval [6] = '{16'h1000, 16'h0000, 16'h2612, 16'h0098, 16'h2010, 16'h0000};
  logic [3:0]  hw [8] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h4, 4'h0, 4'h8, 4'h0};
  int          st [5] = '{0, 32, 2, 0, 0};

  scc_top uut (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) error_cnt++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] e);
    expq.push_back({16'h0000, e});
    bus(1'b0, idx, 16'h0000);
  endtask

  // Pulses stay four cycles high and low so the synchroniser sees every edge.
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      if (p) general_pin_one <= 1'b1;
      else general_pin_zero <= 1'b1;
      repeat (4) @(posedge clock);
      general_pin_zero <= 1'b0;
      general_pin_one  <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (6) @(posedge clock);
  endtask

  task finish_test;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clock) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) chk(wb_dat_o, expq.pop_front());
    if (sample_start === 1'b1) n_start++;
    if (sample_clock_tick === 1'b1) n_tick++;
    if (timing_clock_tick === 1'b1) n_fast++;
  end

  initial begin
    repeat (80000) @(posedge clock);
    error_cnt++;
    finish_test;
  end

  initial begin
    {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, general_pin_zero, general_pin_one} = '0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'h3;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (ridx[k]) rd(ridx[k], rval[k]);
    chk({first_slot_enable, slow_clock_trim, fast_clock_trim}, {1'b0, 6'h12, 8'h98});
    for (i = 0; i < 8; i++) begin
      bus(1'b1, 8'h11, {4'h1, 7'h00, i[2:0], 1'b0, 1'b1});
      repeat (3) @(posedge clock);
      chk({first_slot_fifo_format, fifo_halfwords}, {i[2:0], hw[i]});
    end
    rd(8'h70, 16'h0001);
    repeat (4) begin
      r = 16'($random(seed));
      bus(1'b1, 8'h4B, {7'h13, 3'h0, r[5:0]});
      bus(1'b1, 8'h4D, {8'h00, r[15:8]});
      rd(8'h4B, {7'h13, 3'h0, r[5:0]});
      rd(8'h4D, {8'h00, r[15:8]});
      chk({slow_clock_trim, fast_clock_trim}, {r[5:0], r[15:8]});
    end
    // Rate one on the internal trigger makes every sample tick start a cycle.
    bus(1'b1, 8'h12, 16'h0001);
    bus(1'b1, 8'h11, 16'h1001);
    for (i = 0; i < 3; i++) begin
      bus(1'b1, 8'h4B, i == 2 ? 16'h2612 : (i == 1 ? 16'h26BF : 16'h2680));
      bus(1'b1, 8'h4D, i == 1 ? 16'h00FF : 16'h0000);
      {n_start, n_tick, n_fast} = '0;
      repeat (15000) @(posedge clock);
      cnt[i] = n_tick;
      fst[i] = n_fast;
      chk(n_start, n_tick);
    end
    chk(cnt[0] > cnt[1] && cnt[1] > 0, 1);
    chk(cnt[2], 0);
    chk(fst[1] > fst[0], 1);
    bus(1'b1, 8'h4F, 16'h2030);
    bus(1'b1, 8'h4B, 16'h2792);
    n_tick = 0;
    pulse(1, 5);
    chk(n_tick, 5);
    chk(pin_one_input_enable, 1);
    bus(1'b1, 8'h4B, 16'h2612);
    for (i = 1; i < 5; i++) begin
      bus(1'b1, 8'h4F, {8'h20, 1'b0, 2'b01, 1'b1, i == 4 ? 2'b01 : i[1:0], 2'b10});
      bus(1'b1, 8'h38, i != 3 ? 16'h4000 : 16'h0000);
      rd(8'h70, i == 3 ? 16'h0008 : 16'h0000);
      if (i == 4) bus(1'b1, 8'h11, 16'h1000);
      n_start = 0;
      pulse(0, 2);
      a = n_start;
      pulse(1, 2);
      chk(a * 16 + n_start - a, st[i]);
    end
    finish_test;
  end
endmodule // scc_top_tb_top
